// *** soft_power_wake_status_delay.sv ***
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Status bit set means event since clear
// - Bit 0 latches first receive line fall
// - Bit 1 latches second receive line fall
// - Bit 3 latches ring; enabled ring powers on
// - Bit 5 latches infrared; enabled powers on
// - Bit 2 latches button press, read clears
// - Button status never drives power control
// - Off delay programmable 500 ms to 32 s
// - Delay equals (code plus one) half seconds
// - Delay never short, at most 10 ms long
// - Timer starts on enable, option and button while on
// - Delay register resets to 500 ms code
// - Button power-off enable, default enabled
// - Enables gate ring and infrared power-on
module soft_power_wake_status_delay
  import soft_power_pkg::*;
#(
  parameter int HALF_SEC_CYC = HALF_SEC_CYCLES
) (
  // Clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Wake sources
  input  wire logic        first_serial_receive_line,
  input  wire logic        second_serial_receive_line,
  input  wire logic        ring_indicate_input_n,
  input  wire logic        consumer_infrared,
  input  wire logic        power_button_n,
  // Power control
  output logic             system_power_request_n
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              hreadyout;
    logic              hresp;
    logic [31:0]       hrdata;
    logic              wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic              rd_pend;
    logic [ADDR_W-1:0] rd_addr;
    logic [REG_W-1:0]  delay;
    logic [REG_W-1:0]  control;
    power_state_t      power;
    logic              request_n;
  } main_state_t;

  localparam main_state_t RESET_STATE = '{
    hreadyout: 1'b1,
    hresp:     1'b0,
    hrdata:    32'h0000_0000,
    wr_pend:   1'b0,
    wr_addr:   '0,
    rd_pend:   1'b0,
    rd_addr:   '0,
    delay:     DELAY_RST,
    control:   CONTROL_RST,
    power:     POWER_OFF,
    request_n: 1'b1
  };

  main_state_t s;
  main_state_t next_s;

  logic [REG_W-1:0]  event_level;
  logic [REG_W-1:0]  event_rise;
  logic [REG_W-1:0]  status;
  logic              status_clear;
  logic              timer_start;
  logic              timer_abort;
  logic              timer_busy;
  logic              timer_expired;
  logic              accept;
  logic              button_press;
  logic              wake_request;
  logic              off_en;
  logic              poweroff_delay_option;
  logic              power_is_on;
  logic              power_in_delay;
  logic              press_off;
  logic [REG_W-1:0]  read_byte;

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  // Reserved bits are masked in one place for reads and writes
  function automatic logic [REG_W-1:0] reg_mask(
    input logic [ADDR_W-1:0] addr
  );
    logic [REG_W-1:0] m;
    m = '0;
    unique case (addr)
      STATUS_ADDR:  m = STATUS_MASK;
      DELAY_ADDR:   m = DELAY_MASK;
      CONTROL_ADDR: m = CONTROL_MASK;
      STATE_ADDR: begin
        m[SR_POWER_ON]   = 1'b1;
        m[SR_TIMER_BUSY] = 1'b1;
      end
      default:      m = '0;
    endcase
    return m;
  endfunction : reg_mask

  function automatic logic [REG_W-1:0] read_value(
    input logic [ADDR_W-1:0] addr,
    input logic [REG_W-1:0]  st,
    input main_state_t       cur,
    input logic              busy
  );
    logic [REG_W-1:0] v;
    v = '0;
    unique case (addr)
      STATUS_ADDR:  v = st & STATUS_MASK;
      DELAY_ADDR:   v = cur.delay & DELAY_MASK;
      CONTROL_ADDR: v = cur.control & CONTROL_MASK;
      STATE_ADDR: begin
        v[SR_POWER_ON]   = ~cur.request_n;
        v[SR_TIMER_BUSY] = busy;
      end
      default:      v = '0;
    endcase
    return v & reg_mask(addr);
  endfunction : read_value

  function automatic logic is_addr(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] target
  );
    return addr == target;
  endfunction : is_addr

  // ----------------------------------------------------------------
  // Wake event sources
  // ----------------------------------------------------------------
  // Each source is presented as an active-high level, so a rise on
  // the level marks the documented edge of the pin.
  always_comb begin
    event_level            = '0;
    event_level[ST_FIRST_SERIAL_RECEIVE_LINE]   = ~first_serial_receive_line;
    event_level[ST_SECOND_SERIAL_RECEIVE_LINE]   = ~second_serial_receive_line;
    event_level[ST_BUTTON] = ~power_button_n;
    event_level[ST_RING]   = ~ring_indicate_input_n;
    event_level[ST_IR]     = consumer_infrared;
  end

  // ----------------------------------------------------------------
  // Wake event latches
  // ----------------------------------------------------------------
  // Read clear lands in the data phase of a status read
  assign status_clear = s.rd_pend & is_addr(s.rd_addr, STATUS_ADDR);

  event_latch_bank u_latch (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .clk_en      (clk_en),
    .event_level (event_level),
    .clear_req   (status_clear),
    .event_rise  (event_rise),
    .status      (status)
  );

  // ----------------------------------------------------------------
  // Power control terms
  // ----------------------------------------------------------------
  // Power paths use raw edges, never the latched button status
  assign button_press = event_rise[ST_BUTTON];
  assign off_en       = s.control[CTL_OFF_EN];
  assign poweroff_delay_option      = s.control[CTL_POWEROFF_DELAY_OPTION];

  assign wake_request =
    (event_rise[ST_RING] & s.control[CTL_RING_EN]) |
    (event_rise[ST_IR]   & s.control[CTL_IR_EN]);

  // ----------------------------------------------------------------
  // Power-off delay timer
  // ----------------------------------------------------------------
  // Abort keeps a disabled button from turning power off late
  assign timer_start = power_is_on & press_off & poweroff_delay_option;
  assign timer_abort = power_in_delay & ~off_en;

  poweroff_delay_timer #(
    .HALF_SEC_CYC (HALF_SEC_CYC)
  ) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .start   (timer_start),
    .abort   (timer_abort),
    .code    (s.delay[CODE_W-1:0]),
    .busy    (timer_busy),
    .expired (timer_expired)
  );

  // ----------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------
  // Taken only while ready, so a wait state never drops a request
  assign accept = hsel & hready & htrans[1];

  // ----------------------------------------------------------------
  // Register read data
  // ----------------------------------------------------------------
  // Status is sampled before its clear lands, so no event is lost
  assign read_byte = read_value(s.rd_addr, status, s, timer_busy);

  // ----------------------------------------------------------------
  // Power state decode
  // ----------------------------------------------------------------
  assign power_is_on    = (s.power == POWER_ON);
  assign power_in_delay = (s.power == POWER_DELAY);
  assign press_off      = button_press & off_en;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s       = s;
    next_s.hresp = HRESP_OKAY[0];

    // --------------------------------------------------------------
    // Write data phase: hwdata is valid now
    // --------------------------------------------------------------
    if (s.wr_pend) begin
      next_s.wr_pend = 1'b0;
      unique case (s.wr_addr)
        DELAY_ADDR: begin
          next_s.delay = hwdata[REG_W-1:0] & reg_mask(s.wr_addr);
        end
        CONTROL_ADDR: begin
          next_s.control = hwdata[REG_W-1:0] & reg_mask(s.wr_addr);
        end
        default: begin
          next_s.wr_pend = 1'b0;
        end
      endcase
    end

    // --------------------------------------------------------------
    // Read data phase: one wait state so a write just before lands
    // --------------------------------------------------------------
    if (s.rd_pend) begin
      next_s.rd_pend   = 1'b0;
      next_s.hreadyout = 1'b1;
      next_s.hrdata    = {24'h00_0000, read_byte};
    end

    // --------------------------------------------------------------
    // New address phase
    // --------------------------------------------------------------
    if (accept) begin
      if (hwrite) begin
        next_s.wr_pend = 1'b1;
        next_s.wr_addr = haddr[ADDR_W-1:0];
      end else begin
        next_s.rd_pend   = 1'b1;
        next_s.rd_addr   = haddr[ADDR_W-1:0];
        next_s.hreadyout = 1'b0;
      end
    end

    // --------------------------------------------------------------
    // Soft power sequencing
    // --------------------------------------------------------------
    unique case (s.power)
      POWER_OFF: begin
        if (wake_request | button_press) begin
          next_s.power = POWER_ON;
        end
      end
      POWER_ON: begin
        if (press_off) begin
          if (poweroff_delay_option) begin
            next_s.power = POWER_DELAY;
          end else begin
            next_s.power = POWER_OFF;
          end
        end
      end
      POWER_DELAY: begin
        // Presses here are ignored; the code was latched at start
        if (~off_en) begin
          next_s.power = POWER_ON;
        end else if (timer_expired) begin
          next_s.power = POWER_OFF;
        end
      end
      default: begin
        next_s.power = POWER_OFF;
      end
    endcase

    // --------------------------------------------------------------
    // Request stays asserted through the delay
    // --------------------------------------------------------------
    next_s.request_n = (next_s.power == POWER_OFF);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Clock enable low freezes the bus and the power state alike
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= RESET_STATE;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout              = s.hreadyout;
  assign hresp                  = s.hresp;
  assign hrdata                 = s.hrdata;
  assign system_power_request_n = s.request_n;

  // Only whole-word transfers are used; size is not decoded
  logic unused_ok;
  assign unused_ok = ^{hsize, haddr[31:ADDR_W], htrans[0],
                       hwdata[31:REG_W]};

endmodule : soft_power_wake_status_delay
`default_nettype wire

// *** soft_power_pkg.sv ***
`default_nettype none
package soft_power_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam int         ADDR_W        = 10;
  localparam logic [7:0] STATUS_IDX    = 8'hB3;
  localparam logic [7:0] DELAY_IDX     = 8'hB8;
  localparam logic [7:0] CONTROL_IDX   = 8'hB9;
  localparam logic [7:0] STATE_IDX     = 8'hBA;
  localparam logic [9:0] STATUS_ADDR   = {STATUS_IDX, 2'h0};
  localparam logic [9:0] DELAY_ADDR    = {DELAY_IDX, 2'h0};
  localparam logic [9:0] CONTROL_ADDR  = {CONTROL_IDX, 2'h0};
  localparam logic [9:0] STATE_ADDR    = {STATE_IDX, 2'h0};

  // ----------------------------------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam int         REG_W         = 8;
  localparam int         ST_FIRST_SERIAL_RECEIVE_LINE       = 0;
  localparam int         ST_SECOND_SERIAL_RECEIVE_LINE       = 1;
  localparam int         ST_BUTTON     = 2;
  localparam int         ST_RING       = 3;
  localparam int         ST_IR         = 5;
  localparam logic [7:0] STATUS_MASK   = 8'h2F;
  localparam logic [7:0] STATUS_RST    = 8'h00;
  localparam int         CODE_W        = 6;
  localparam logic [7:0] DELAY_MASK    = 8'h3F;
  localparam logic [7:0] DELAY_RST     = 8'h00;
  localparam int         CTL_RING_EN   = 3;
  localparam int         CTL_IR_EN     = 5;
  localparam int         CTL_POWEROFF_DELAY_OPTION   = 6;
  localparam int         CTL_OFF_EN    = 7;
  localparam logic [7:0] CONTROL_MASK  = 8'hE8;
  localparam logic [7:0] CONTROL_RST   = 8'h80;
  localparam int         SR_POWER_ON   = 0;
  localparam int         SR_TIMER_BUSY = 1;

  // ----------------------------------------------------------------
  // Bus codes
  // ----------------------------------------------------------------
  localparam logic [1:0] HRESP_OKAY    = 2'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int HALF_SEC_MS     = 500;
  localparam int CLK_KHZ         = 250000;
  localparam int HALF_SEC_CYCLES = HALF_SEC_MS * CLK_KHZ;
  localparam int PRESCALE_W      = 27;

  typedef enum logic [1:0] {
    POWER_OFF,
    POWER_ON,
    POWER_DELAY
  } power_state_t;

endpackage : soft_power_pkg
`default_nettype wire

// *** event_latch_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module event_latch_bank
  import soft_power_pkg::*;
(
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             clk_en,
  // Events
  input  wire logic [REG_W-1:0] event_level,
  input  wire logic             clear_req,
  output logic      [REG_W-1:0] event_rise,
  output logic      [REG_W-1:0] status
);

  typedef struct packed {
    logic [REG_W-1:0] prev;
    logic [REG_W-1:0] flag;
  } latch_state_t;

  latch_state_t s;
  latch_state_t next_s;

  // ----------------------------------------------------------------
  // Edge detect per source
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < REG_W; g++) begin : g_edge
      assign event_rise[g] = event_level[g] & ~s.prev[g];
    end
  endgenerate

  assign status = s.flag & STATUS_MASK;

  // New event beats a read clear in the same cycle
  always_comb begin
    next_s      = s;
    next_s.prev = event_level;
    next_s.flag = event_rise | (s.flag & {REG_W{~clear_req}});
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{prev: '0, flag: STATUS_RST};
    end else if (clk_en) begin
      s <= next_s;
    end
  end

endmodule : event_latch_bank
`default_nettype wire

// *** poweroff_delay_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module poweroff_delay_timer
  import soft_power_pkg::*;
#(
  parameter int HALF_SEC_CYC = HALF_SEC_CYCLES
) (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              clk_en,
  // Control
  input  wire logic              start,
  input  wire logic              abort,
  input  wire logic [CODE_W-1:0] code,
  output logic                   busy,
  output logic                   expired
);

  localparam logic [PRESCALE_W-1:0] PRESCALE_LAST =
    PRESCALE_W'(HALF_SEC_CYC - 1);

  typedef struct packed {
    logic                  busy;
    logic                  expired;
    logic [PRESCALE_W-1:0] prescale;
    logic [CODE_W-1:0]     ticks;
    logic [CODE_W-1:0]     code;
  } timer_state_t;

  timer_state_t s;
  timer_state_t next_s;

  assign busy    = s.busy;
  assign expired = s.expired;

  // Code is held at start so a rewrite cannot stretch a running delay
  always_comb begin
    next_s         = s;
    next_s.expired = 1'b0;
    if (abort) begin
      next_s.busy = 1'b0;
    end else if (s.busy) begin
      if (s.prescale == PRESCALE_LAST) begin
        next_s.prescale = '0;
        if (s.ticks == s.code) begin
          next_s.busy    = 1'b0;
          next_s.expired = 1'b1;
        end else begin
          next_s.ticks = s.ticks + CODE_W'(1);
        end
      end else begin
        next_s.prescale = s.prescale + PRESCALE_W'(1);
      end
    end else if (start) begin
      next_s.busy     = 1'b1;
      next_s.prescale = '0;
      next_s.ticks    = '0;
      next_s.code     = code;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

endmodule : poweroff_delay_timer
`default_nettype wire

// *** soft_power_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module soft_power_props
  import soft_power_pkg::*;
#(
  parameter int HALF_SEC_CYC = HALF_SEC_CYCLES
) (
  // Bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        clk_en,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Wake and power
  input wire logic        ring_indicate_input_n,
  input wire logic        consumer_infrared,
  input wire logic        power_button_n,
  input wire logic        system_power_request_n
);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  // Longest delay plus slack; saturating so a stray rise still fails
  localparam int LIMIT = 64 * HALF_SEC_CYC + 4;
  logic [2:0]  prev;
  logic [31:0] since;
  logic        ev_btn;
  logic        ev_any;
  logic        taken;
  assign ev_btn = prev[2] & ~power_button_n;
  assign ev_any = ev_btn | (prev[1] & ~ring_indicate_input_n)
                | (~prev[0] & consumer_infrared);
  assign taken  = hsel & hready & htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev  <= 3'h6;
      since <= 32'(LIMIT + 1);
    end else begin
      prev  <= {power_button_n, ring_indicate_input_n, consumer_infrared};
      since <= ev_btn ? 32'h0 : (since > LIMIT ? since : since + 32'h1);
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn || !clk_en);
  a_read_wait: assert property (
    taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (
    taken && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (
    hresp == 1'b0)
    else $error("response not okay");
  a_upper_zero: assert property (
    hrdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_data_hold: assert property (
    !$rose(hreadyout) |-> $stable(hrdata))
    else $error("read data moved outside data phase");
  a_press_on: assert property (
    ev_btn && system_power_request_n |-> ##[1:3] !system_power_request_n)
    else $error("press did not power on");
  a_on_has_cause: assert property (
    $fell(system_power_request_n)
      |-> $past(ev_any) || $past(ev_any, 2) || $past(ev_any, 3))
    else $error("power on without wake edge");
  a_off_bounded: assert property (
    $rose(system_power_request_n) |-> since <= LIMIT)
    else $error("power off without recent press");
endmodule : soft_power_props
`default_nettype wire

// *** wake_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module wake_source_model (
  // Clock
  input  wire logic hclk,
  // Source lines
  output wire logic first_serial_receive_line,
  output wire logic second_serial_receive_line,
  output wire logic ring_indicate_input_n,
  output wire logic consumer_infrared,
  output wire logic power_button_n
);
  // Idle: receive lines mark high, ring and button released, IR quiet
  localparam logic [4:0] IDLE = 5'h17;
  logic [4:0] act = 5'h00;
  assign {power_button_n, consumer_infrared, ring_indicate_input_n,
          second_serial_receive_line, first_serial_receive_line} = IDLE ^ act;
  // Held three cycles so any edge detector sees a clean pulse
  task automatic pulse(input int idx);
    @(posedge hclk);
    act[idx] <= 1'b1;
    repeat (3) @(posedge hclk);
    act[idx] <= 1'b0;
  endtask : pulse
endmodule : wake_source_model
`default_nettype wire

// *** tb_soft_power_wake_status_delay.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_soft_power_wake_status_delay;
  import soft_power_pkg::*;
  localparam int H = 10;
  logic        hclk;
  logic        hresetn;
  logic        clk_en;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        system_power_request_n;
  wire logic   rx1;
  wire logic   rx2;
  wire logic   ring_n;
  wire logic   ir;
  wire logic   btn_n;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;

  soft_power_wake_status_delay #(.HALF_SEC_CYC(H)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .first_serial_receive_line(rx1),
    .second_serial_receive_line(rx2), .ring_indicate_input_n(ring_n),
    .consumer_infrared(ir), .power_button_n(btn_n),
    .system_power_request_n(system_power_request_n));
  wake_source_model src_u (
    .hclk(hclk), .first_serial_receive_line(rx1),
    .second_serial_receive_line(rx2), .ring_indicate_input_n(ring_n),
    .consumer_infrared(ir), .power_button_n(btn_n));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Master waits on hready with no assumed latency
  task automatic bus(input logic w, input logic [9:0] a,
                     input logic [7:0] wd, output logic [31:0] rdata);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {22'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask : bus
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    logic [31:0] x;
    bus(1'b0, a, 8'h00, x);
    chk(x, {24'h0, e});
  endtask : rd
  task automatic pin(input logic e);
    @(negedge hclk);
    chk({31'h0, system_power_request_n}, {31'h0, e});
  endtask : pin
  task automatic off_delay(input logic [5:0] code);
    logic [31:0] n;
    n = 32'h0;
    wr(DELAY_ADDR, {2'h0, code});
    src_u.pulse(2);
    pin(1'b0);
    src_u.pulse(4);
    while (system_power_request_n !== 1'b1 && n < 32'd2000) begin
      @(posedge hclk);
      #1;
      n++;
    end
    // Press sampled two edges before counting; output register adds one
    chk(n + 32'd2, 32'((code + 1) * H + 1));
    rd(STATUS_ADDR, 8'h0C);
  endtask : off_delay

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    hresetn = 1'b0;
    clk_en  = 1'b1;
    hsel    = 1'b0;
    htrans  = 2'h0;
    haddr   = 32'h0;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd(STATUS_ADDR, 8'h00);
    rd(DELAY_ADDR, 8'h00);
    rd(CONTROL_ADDR, 8'h80);
    rd(10'h000, 8'h00);
    src_u.pulse(0);
    rd(STATUS_ADDR, 8'h01);
    rd(STATUS_ADDR, 8'h00);
    src_u.pulse(1);
    rd(STATUS_ADDR, 8'h02);
    // A pulse wholly inside a frozen span must leave no trace
    clk_en <= 1'b0;
    src_u.pulse(0);
    @(posedge hclk);
    clk_en <= 1'b1;
    rd(STATUS_ADDR, 8'h00);
    src_u.pulse(2);
    src_u.pulse(3);
    pin(1'b1);
    rd(STATUS_ADDR, 8'h28);
    wr(STATUS_ADDR, 8'hFF);
    wr(DELAY_ADDR, 8'hFF);
    rd(STATUS_ADDR, 8'h00);
    rd(DELAY_ADDR, 8'h3F);
    wr(CONTROL_ADDR, 8'hE8);
    off_delay(6'h00);
    off_delay(6'h3F);
    wr(CONTROL_ADDR, 8'h28);
    src_u.pulse(3);
    src_u.pulse(4);
    repeat (5) @(posedge hclk);
    pin(1'b0);
    rd(STATE_ADDR, 8'h01);
    rd(STATUS_ADDR, 8'h24);
    pin(1'b0);
    wr(CONTROL_ADDR, 8'hA8);
    src_u.pulse(4);
    pin(1'b1);
    src_u.pulse(4);
    pin(1'b0);
    stop_test();
  end
endmodule : tb_soft_power_wake_status_delay

bind soft_power_wake_status_delay soft_power_props
  #(.HALF_SEC_CYC(HALF_SEC_CYC)) props_u (
  .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
  .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata),
  .ring_indicate_input_n(ring_indicate_input_n),
  .consumer_infrared(consumer_infrared), .power_button_n(power_button_n),
  .system_power_request_n(system_power_request_n));
`default_nettype wire
